/* bench/test_voltage_list_ramp_sequencer.sv */
`timescale 1ns/100ps
`include "vlrs_defines.svh"
module test_voltage_list_ramp_sequencer;
    logic core_clk_i, srst_i, cyc, stb, we, ack, irq, tout, ext_t, bkp_t;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [15:0] sp;
    int errors, compares;

    // One ms per cycle keeps a 10 ms dwell at 11 cycles a step
    vlrs_top #(.CYC_PER_MS(1), .PULSE_CYC(4)) u_vlrs_top (
        .core_clk_i(core_clk_i), .srst_i(srst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .ext_trig_i(ext_t),
        .backplane_trigger_line_i(bkp_t), .trig_out_o(tout),
        .voltage_setpoint_o(sp), .irq_o(irq));
    vlrs_host_trig_model u_vlrs_host_trig_model (
        .core_clk_i(core_clk_i), .ext_trig_o(ext_t), .backplane_trigger_line_o(bkp_t));

    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hF;
        do begin
            @(posedge core_clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        if (n >= 20) begin
            chk(32'h0, 32'h1);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge core_clk_i);
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd

    task automatic sp_chk(input int n, input logic [15:0] e);
        repeat (n) @(posedge core_clk_i);
        chk({16'h0, sp}, {16'h0, e});
    endtask : sp_chk

    task automatic wait_tout(input int lim);
        int n;
        n = 0;
        while (tout !== 1'b1 && n < lim) begin
            @(posedge core_clk_i);
            n++;
        end
        chk({31'h0, tout}, 32'h1);
    endtask : wait_tout

    task automatic arm();
        int n;
        n = 0;
        wb(1'b1, `VLRS_OFS_CMD, 32'h1);
        do begin
            wb(1'b0, `VLRS_OFS_OPER, 32'h0);
            n++;
        end while (q[5] !== 1'b1 && n < 10);
        chk(q & 32'h20, 32'h20);
    endtask : arm

    task automatic complete_run();
        if (errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run

    initial begin
        errors = 0;
        compares = 0;
        srst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        repeat (16) @(posedge core_clk_i);
        srst_i <= 1'b0;
        @(posedge core_clk_i);
        rd(`VLRS_OFS_COUNT, 32'h1);
        rd(`VLRS_OFS_LEN, 32'h14);
        rd(`VLRS_OFS_OPER, 32'h0);
        rd(8'hFC, 32'h0);
        wb(1'b1, `VLRS_OFS_LEVEL, 32'h1234);
        wb(1'b1, `VLRS_OFS_CTRL, 32'h13);
        sp_chk(2, 16'h1234);
        u_vlrs_host_trig_model.fire(1'b0);
        sp_chk(4, 16'h1234);
        wb(1'b1, `VLRS_OFS_LEN, 32'h3);
        wb(1'b1, `VLRS_OFS_NDWELL, 32'h1);
        // Shortest legal dwell, and a second dwell that must go unused
        wb(1'b1, `VLRS_OFS_DLIST, 32'hA);
        wb(1'b1, `VLRS_OFS_DLIST + 8'h04, 32'h30);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, `VLRS_OFS_VLIST + 8'(4 * i), 32'h100 * (i + 1));
        end
        wb(1'b1, `VLRS_OFS_IMSK, 32'h1);
        arm();
        wb(1'b1, `VLRS_OFS_CMD, 32'h2);
        sp_chk(6, 16'h0100);
        sp_chk(12, 16'h0200);
        rd(`VLRS_OFS_IST, 32'h2);
        wait_tout(12);
        sp_chk(6, 16'h0300);
        sp_chk(30, 16'h0300);
        rd(`VLRS_OFS_IST, 32'h3);
        chk({31'h0, irq}, 32'h1);
        wb(1'b1, `VLRS_OFS_IST, 32'h3);
        repeat (2) @(posedge core_clk_i);
        chk({31'h0, irq}, 32'h0);
        wb(1'b1, `VLRS_OFS_COUNT, 32'h0);
        for (int s = 0; s < 2; s++) begin
            wb(1'b1, `VLRS_OFS_CTRL, 32'h23 | (32'h4 << s));
            arm();
            u_vlrs_host_trig_model.fire(s[0]);
            wait_tout(8);
            sp_chk(4, 16'h0100);
            sp_chk(36, 16'h0100);
            wb(1'b1, `VLRS_OFS_CMD, 32'h4);
        end
        // Without auto stepping each trigger steps once; two passes, then the last entry holds
        wb(1'b1, `VLRS_OFS_COUNT, 32'h2);
        wb(1'b1, `VLRS_OFS_CTRL, 32'h1);
        wb(1'b1, `VLRS_OFS_IST, 32'h3);
        arm();
        for (int k = 0; k < 6; k++) begin
            wb(1'b1, `VLRS_OFS_CMD, 32'h2);
            sp_chk(1, 16'((k % 3 + 1) * 256));
            rd(`VLRS_OFS_IST, 32'h2 | 32'(k / 5));
        end
        wb(1'b1, `VLRS_OFS_CMD, 32'h2);
        sp_chk(1, 16'h0300);
        rd(`VLRS_OFS_OPER, 32'h0);
        complete_run();
    end

    initial begin
        repeat (3000) @(posedge core_clk_i);
        errors++;
        complete_run();
    end
endmodule : test_voltage_list_ramp_sequencer

/* bench/vlrs_host_trig_model.sv */
`timescale 1ns/100ps
module vlrs_host_trig_model (
    // Clock
    input wire logic core_clk_i,
    // Trigger lines toward the device
    output logic ext_trig_o,
    output logic backplane_trigger_line_o
);
    initial begin
        ext_trig_o = 1'b0;
        backplane_trigger_line_o = 1'b0;
    end

    // Lines idle low; two cycles high gives the edge detector a clean rise
    task automatic fire(input logic bkp);
        if (bkp) begin
            backplane_trigger_line_o <= 1'b1;
        end else begin
            ext_trig_o <= 1'b1;
        end
        repeat (2) @(posedge core_clk_i);
        ext_trig_o <= 1'b0;
        backplane_trigger_line_o <= 1'b0;
    endtask : fire
endmodule : vlrs_host_trig_model

/* design/vlrs_defines.svh */
`ifndef VLRS_DEFINES_SVH
`define VLRS_DEFINES_SVH

// Register byte offsets
`define VLRS_OFS_CTRL 8'h00
`define VLRS_OFS_CMD 8'h04
`define VLRS_OFS_OPER 8'h08
`define VLRS_OFS_IST 8'h0C
`define VLRS_OFS_IMSK 8'h10
`define VLRS_OFS_LEVEL 8'h14
`define VLRS_OFS_COUNT 8'h18
`define VLRS_OFS_LEN 8'h1C
`define VLRS_OFS_NDWELL 8'h20
`define VLRS_OFS_VLIST 8'h40
`define VLRS_OFS_DLIST 8'hA0

// Control register fields
`define VLRS_CTRL_W 6
`define VLRS_CTRL_LIST 0
`define VLRS_CTRL_AUTO 1
`define VLRS_CTRL_SRC_EXT 2
`define VLRS_CTRL_SRC_BKP 3
`define VLRS_CTRL_TOUT_DONE 4
`define VLRS_CTRL_TOUT_PT 5

// Command register fields
`define VLRS_CMD_INIT 0
`define VLRS_CMD_TRIG 1
`define VLRS_CMD_ABORT 2

// Operation condition fields
`define VLRS_OPER_RUN 4
`define VLRS_OPER_WTG 5

// Interrupt status and mask fields
`define VLRS_IST_W 2
`define VLRS_IST_DONE 0
`define VLRS_IST_PT 1

// Sizes and reset values
`define VLRS_LIST_DEPTH 20
`define VLRS_VAL_W 16
`define VLRS_DWELL_W 16
`define VLRS_RST_COUNT 16'h0001
`define VLRS_COUNT_INF 16'h0000
`define VLRS_MIN_DWELL_MS 16'h000A

// Timing
`define VLRS_CLK_PERIOD_NS 10
`define VLRS_NS_PER_MS 1000000
`define VLRS_CYC_PER_MS (`VLRS_NS_PER_MS / `VLRS_CLK_PERIOD_NS)
`define VLRS_TRIG_PULSE_NS 1000
`define VLRS_TRIG_PULSE_CYC ((`VLRS_TRIG_PULSE_NS + `VLRS_CLK_PERIOD_NS - 1) / `VLRS_CLK_PERIOD_NS)

`endif

/* design/vlrs_dwell_timer.sv */
`timescale 1ns/100ps
`include "vlrs_defines.svh"
module vlrs_dwell_timer #(
    parameter int CYC_PER_MS = `VLRS_CYC_PER_MS
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Sequencer side
    vlrs_seq_if.tmr sif
);
    localparam int PW = $clog2(CYC_PER_MS + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(CYC_PER_MS - 1);

    logic [PW-1:0] pre_r, pre_nxt;
    logic [`VLRS_DWELL_W-1:0] ms_r, ms_nxt;
    logic act_r, act_nxt;
    logic exp_r, exp_nxt;

    // Prescaler restarts on load so each dwell starts on a whole millisecond
    always_comb begin
        pre_nxt = pre_r;
        ms_nxt = ms_r;
        act_nxt = act_r;
        exp_nxt = 1'b0;
        if (sif.dwell_load) begin
            pre_nxt = '0;
            ms_nxt = sif.dwell_ms;
            act_nxt = 1'b1;
        end else if (act_r) begin
            if (pre_r == PRE_LAST) begin
                pre_nxt = '0;
                if (ms_r <= `VLRS_DWELL_W'(1)) begin
                    exp_nxt = 1'b1;
                    act_nxt = 1'b0;
                end else begin
                    ms_nxt = ms_r - `VLRS_DWELL_W'(1);
                end
            end else begin
                pre_nxt = pre_r + PW'(1);
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            pre_r <= '0;
            ms_r <= '0;
            act_r <= 1'b0;
            exp_r <= 1'b0;
        end else begin
            pre_r <= pre_nxt;
            ms_r <= ms_nxt;
            act_r <= act_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign sif.dwell_expire = exp_r;

    property p_expire_from_run;
        @(posedge core_clk_i) disable iff (srst_i)
        exp_r |-> $past(act_r) && !act_r;
    endproperty
    a_expire_from_run: assert property (p_expire_from_run) else $error("dwell expired while idle");
endmodule : vlrs_dwell_timer

/* design/vlrs_pkg.sv */
package vlrs_pkg;
    typedef enum logic [1:0] {
        S_IDLE,
        S_ARMED,
        S_RUN
    } vlrs_state_t;
endpackage : vlrs_pkg

/* design/vlrs_pulse_gen.sv */
`timescale 1ns/100ps
module vlrs_pulse_gen #(
    parameter int WIDTH = 100
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Sequencer side
    vlrs_seq_if.pls sif
);
    localparam int CW = $clog2(WIDTH + 1);

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic out_r, out_nxt;

    // A new fire while busy stretches the pulse rather than making a glitch
    always_comb begin
        cnt_nxt = cnt_r;
        out_nxt = out_r;
        if (sif.pulse_fire) begin
            cnt_nxt = CW'(WIDTH);
            out_nxt = 1'b1;
        end else if (cnt_r > CW'(1)) begin
            cnt_nxt = cnt_r - CW'(1);
        end else begin
            cnt_nxt = '0;
            out_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cnt_r <= '0;
            out_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= out_nxt;
        end
    end

    assign sif.pulse_out = out_r;

    property p_fire_drives;
        @(posedge core_clk_i) disable iff (srst_i)
        sif.pulse_fire |=> out_r;
    endproperty
    a_fire_drives: assert property (p_fire_drives) else $error("trigger out pulse missing");
endmodule : vlrs_pulse_gen

/* design/vlrs_seq_if.sv */
`timescale 1ns/100ps
`include "vlrs_defines.svh"
interface vlrs_seq_if;
    logic dwell_load;
    logic [`VLRS_DWELL_W-1:0] dwell_ms;
    logic dwell_expire;
    logic pulse_fire;
    logic pulse_out;
    modport seq (output dwell_load, output dwell_ms, output pulse_fire, input dwell_expire, input pulse_out);
    modport tmr (input dwell_load, input dwell_ms, output dwell_expire);
    modport pls (input pulse_fire, output pulse_out);
endinterface : vlrs_seq_if

/* design/vlrs_top.sv */
// Notes on behaviour
// - Holds up to twenty setpoints and applies them in list order.
// - In list mode the output follows the list once triggered, not the fixed level.
// - Auto stepping holds each entry its dwell, then advances by itself.
// - Dwell is at least ten milliseconds; timer resolves one millisecond.
// - After the final dwell the last entry stays until host reprograms.
// - With one dwell downloaded, every entry uses that dwell.
// - Host arms with initiate; only a trigger while armed starts the list.
// - Waiting for trigger shows as bit 5 of operation condition.
// - Immediate trigger command is always accepted, whatever the source.
// - External input or backplane line may start the list when enabled.
// - Optional service request when the final transition completes.
// - Optional trigger out pulse when the transition finishes.
// - Optional trigger out pulse at each applied list entry.
// - Devices armed alike start together on one shared trigger.
// - Dwell ranges ten milliseconds to sixty-five seconds.
// - Repeat count supported, zero meaning repeat forever.
`timescale 1ns/100ps
`include "vlrs_defines.svh"
module vlrs_top #(
    parameter int LIST_DEPTH = `VLRS_LIST_DEPTH,
    parameter int CYC_PER_MS = `VLRS_CYC_PER_MS,
    parameter int PULSE_CYC = `VLRS_TRIG_PULSE_CYC
) (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Triggers
    input wire logic ext_trig_i,
    input wire logic backplane_trigger_line_i,
    output logic trig_out_o,
    // Regulator and host
    output logic [`VLRS_VAL_W-1:0] voltage_setpoint_o,
    output logic irq_o
);
    localparam int IW = $clog2(LIST_DEPTH + 1);
    localparam logic [IW-1:0] DEPTH_I = IW'(LIST_DEPTH);
    localparam logic [IW-1:0] ONE_I = IW'(1);
    localparam logic [5:0] VW0 = 6'(`VLRS_OFS_VLIST >> 2);
    localparam logic [5:0] DW0 = 6'(`VLRS_OFS_DLIST >> 2);

    vlrs_seq_if sif ();

    // Bus and register state
    logic ack_r, ack_nxt;
    logic [31:0] dat_r, dat_nxt;
    logic [`VLRS_CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [`VLRS_IST_W-1:0] ist_r, ist_nxt;
    logic [`VLRS_IST_W-1:0] imsk_r, imsk_nxt;
    logic [`VLRS_VAL_W-1:0] level_r, level_nxt;
    logic [15:0] count_r, count_nxt;
    logic [IW-1:0] len_r, len_nxt;
    logic [IW-1:0] ndw_r, ndw_nxt;
    logic irq_r, irq_nxt;
    logic [`VLRS_VAL_W-1:0] vlist_r [LIST_DEPTH];
    logic [`VLRS_DWELL_W-1:0] dlist_r [LIST_DEPTH];

    // Sequencer state
    vlrs_pkg::vlrs_state_t st_r, st_nxt;
    logic [IW-1:0] idx_r, idx_nxt;
    logic [15:0] rep_r, rep_nxt;
    logic act_r, act_nxt;
    logic [`VLRS_VAL_W-1:0] sp_r, sp_nxt;
    logic ext_q_r, bkp_q_r;

    logic req, wr_go, cmd_wr, cmd_init, cmd_trig, cmd_abort;
    logic trig, adv, applied, evt_done, evt_pt, last;
    logic [31:0] wmask, rd;
    logic [`VLRS_DWELL_W-1:0] load_ms;

    function automatic logic [IW-1:0] clamp_len(input logic [31:0] v);
        if (v[15:0] == 16'h0000) begin
            return ONE_I;
        end
        if (v[15:0] > 16'(LIST_DEPTH)) begin
            return DEPTH_I;
        end
        return v[IW-1:0];
    endfunction : clamp_len

    // Shorter dwells are raised to the minimum; 16 bits of ms reach 65.5 s
    function automatic logic [`VLRS_DWELL_W-1:0] dwell_of(input logic [IW-1:0] i);
        logic [`VLRS_DWELL_W-1:0] d;
        d = (ndw_r == ONE_I) ? dlist_r[0] : dlist_r[i];
        return (d < `VLRS_MIN_DWELL_MS) ? `VLRS_MIN_DWELL_MS : d;
    endfunction : dwell_of

    // Writes land on the edge where the master sees ack
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_go = req & wb_we_i & ack_r;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign cmd_wr = wr_go & (wb_adr_i == `VLRS_OFS_CMD) & wb_sel_i[0];
    assign cmd_init = cmd_wr & wb_dat_i[`VLRS_CMD_INIT];
    assign cmd_trig = cmd_wr & wb_dat_i[`VLRS_CMD_TRIG];
    assign cmd_abort = cmd_wr & wb_dat_i[`VLRS_CMD_ABORT];

    // Immediate trigger bypasses the source selection
    assign trig = cmd_trig
        | (ctrl_r[`VLRS_CTRL_SRC_EXT] & ext_trig_i & ~ext_q_r)
        | (ctrl_r[`VLRS_CTRL_SRC_BKP] & backplane_trigger_line_i & ~bkp_q_r);

    always_comb begin
        rd = 32'h0000_0000;
        case (wb_adr_i)
            `VLRS_OFS_CTRL: rd = 32'(ctrl_r);
            `VLRS_OFS_OPER: begin
                rd[`VLRS_OPER_WTG] = (st_r == vlrs_pkg::S_ARMED);
                rd[`VLRS_OPER_RUN] = (st_r == vlrs_pkg::S_RUN);
            end
            `VLRS_OFS_IST: rd = 32'(ist_r);
            `VLRS_OFS_IMSK: rd = 32'(imsk_r);
            `VLRS_OFS_LEVEL: rd = 32'(level_r);
            `VLRS_OFS_COUNT: rd = 32'(count_r);
            `VLRS_OFS_LEN: rd = 32'(len_r);
            `VLRS_OFS_NDWELL: rd = 32'(ndw_r);
            default: begin
                for (int k = 0; k < LIST_DEPTH; k++) begin
                    if (wb_adr_i[7:2] == VW0 + 6'(k)) begin
                        rd = 32'(vlist_r[k]);
                    end
                    if (wb_adr_i[7:2] == DW0 + 6'(k)) begin
                        rd = 32'(dlist_r[k]);
                    end
                end
            end
        endcase
    end

    always_comb begin
        ack_nxt = req & ~ack_r;
        dat_nxt = (req & ~ack_r) ? rd : 32'h0000_0000;
        ctrl_nxt = ctrl_r;
        imsk_nxt = imsk_r;
        level_nxt = level_r;
        count_nxt = count_r;
        len_nxt = len_r;
        ndw_nxt = ndw_r;
        ist_nxt = ist_r;
        if (wr_go) begin
            case (wb_adr_i)
                `VLRS_OFS_CTRL: ctrl_nxt = (ctrl_r & ~wmask[`VLRS_CTRL_W-1:0]) | (wb_dat_i[`VLRS_CTRL_W-1:0] & wmask[`VLRS_CTRL_W-1:0]);
                `VLRS_OFS_IMSK: imsk_nxt = (imsk_r & ~wmask[`VLRS_IST_W-1:0]) | (wb_dat_i[`VLRS_IST_W-1:0] & wmask[`VLRS_IST_W-1:0]);
                `VLRS_OFS_IST: ist_nxt = ist_r & ~(wb_dat_i[`VLRS_IST_W-1:0] & wmask[`VLRS_IST_W-1:0]);
                `VLRS_OFS_LEVEL: level_nxt = (level_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                `VLRS_OFS_COUNT: count_nxt = (count_r & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                `VLRS_OFS_LEN: len_nxt = clamp_len(wb_dat_i);
                `VLRS_OFS_NDWELL: ndw_nxt = clamp_len(wb_dat_i);
                default: ;
            endcase
        end
        // Hardware set wins over a same-cycle write-one clear
        ist_nxt[`VLRS_IST_DONE] = ist_nxt[`VLRS_IST_DONE] | evt_done;
        ist_nxt[`VLRS_IST_PT] = ist_nxt[`VLRS_IST_PT] | evt_pt;
        irq_nxt = |(ist_r & imsk_r);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
            ctrl_r <= '0;
            ist_r <= '0;
            imsk_r <= '0;
            level_r <= '0;
            count_r <= `VLRS_RST_COUNT;
            len_r <= DEPTH_I;
            ndw_r <= DEPTH_I;
            irq_r <= 1'b0;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
            ctrl_r <= ctrl_nxt;
            ist_r <= ist_nxt;
            imsk_r <= imsk_nxt;
            level_r <= level_nxt;
            count_r <= count_nxt;
            len_r <= len_nxt;
            ndw_r <= ndw_nxt;
            irq_r <= irq_nxt;
        end
    end

    generate
        for (genvar g = 0; g < LIST_DEPTH; g++) begin : g_entry
            logic [`VLRS_VAL_W-1:0] v_nxt;
            logic [`VLRS_DWELL_W-1:0] d_nxt;
            assign v_nxt = (wr_go && wb_adr_i[7:2] == VW0 + 6'(g)) ?
                ((vlist_r[g] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0])) : vlist_r[g];
            assign d_nxt = (wr_go && wb_adr_i[7:2] == DW0 + 6'(g)) ?
                ((dlist_r[g] & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0])) : dlist_r[g];
            always_ff @(posedge core_clk_i) begin
                if (srst_i) begin
                    vlist_r[g] <= '0;
                    dlist_r[g] <= '0;
                end else begin
                    vlist_r[g] <= v_nxt;
                    dlist_r[g] <= d_nxt;
                end
            end
        end
    endgenerate

    // Sequencer; without auto stepping each trigger advances one entry
    assign last = (idx_r == len_r - ONE_I);
    assign adv = ctrl_r[`VLRS_CTRL_AUTO] ? sif.dwell_expire : trig;

    always_comb begin
        st_nxt = st_r;
        idx_nxt = idx_r;
        rep_nxt = rep_r;
        act_nxt = act_r;
        applied = 1'b0;
        case (st_r)
            vlrs_pkg::S_IDLE: begin
                if (cmd_init) begin
                    st_nxt = vlrs_pkg::S_ARMED;
                end
            end
            vlrs_pkg::S_ARMED: begin
                // Shared backplane or bus trigger starts every armed unit at once
                if (trig && !cmd_abort) begin
                    st_nxt = vlrs_pkg::S_RUN;
                    idx_nxt = '0;
                    rep_nxt = count_r;
                    act_nxt = 1'b1;
                    applied = 1'b1;
                end
            end
            vlrs_pkg::S_RUN: begin
                if (adv && !cmd_abort) begin
                    if (!last) begin
                        idx_nxt = idx_r + ONE_I;
                        applied = 1'b1;
                    end else if (rep_r == `VLRS_COUNT_INF || rep_r > 16'h0001) begin
                        idx_nxt = '0;
                        rep_nxt = (rep_r == `VLRS_COUNT_INF) ? rep_r : rep_r - 16'h0001;
                        applied = 1'b1;
                    end else begin
                        st_nxt = vlrs_pkg::S_IDLE;
                    end
                end
            end
            default: st_nxt = vlrs_pkg::S_IDLE;
        endcase
        if (cmd_abort) begin
            st_nxt = vlrs_pkg::S_IDLE;
            applied = 1'b0;
        end
        // Leaving list mode or rewriting the level hands the output back
        if (!ctrl_r[`VLRS_CTRL_LIST] || (wr_go && wb_adr_i == `VLRS_OFS_LEVEL)) begin
            act_nxt = 1'b0;
        end
        sp_nxt = (ctrl_nxt[`VLRS_CTRL_LIST] && act_nxt) ? vlist_r[idx_nxt] : level_nxt;
        load_ms = dwell_of(idx_nxt);
    end

    assign evt_pt = applied;
    assign evt_done = applied && idx_nxt == len_r - ONE_I && rep_nxt == 16'h0001;
    assign sif.dwell_load = applied;
    assign sif.dwell_ms = load_ms;
    assign sif.pulse_fire = (evt_pt & ctrl_r[`VLRS_CTRL_TOUT_PT])
        | (evt_done & ctrl_r[`VLRS_CTRL_TOUT_DONE]);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_r <= vlrs_pkg::S_IDLE;
            idx_r <= '0;
            rep_r <= '0;
            act_r <= 1'b0;
            sp_r <= '0;
            ext_q_r <= 1'b0;
            bkp_q_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            idx_r <= idx_nxt;
            rep_r <= rep_nxt;
            act_r <= act_nxt;
            sp_r <= sp_nxt;
            ext_q_r <= ext_trig_i;
            bkp_q_r <= backplane_trigger_line_i;
        end
    end

    vlrs_dwell_timer #(.CYC_PER_MS(CYC_PER_MS)) u_timer (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .sif(sif.tmr)
    );

    vlrs_pulse_gen #(.WIDTH(PULSE_CYC)) u_pulse (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .sif(sif.pls)
    );

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign trig_out_o = sif.pulse_out;
    assign voltage_setpoint_o = sp_r;
    assign irq_o = irq_r;

    sequence s_last_expire;
        st_r == vlrs_pkg::S_RUN && last && adv && rep_r == 16'h0001 && !cmd_abort;
    endsequence
    sequence s_hold_final;
        st_r == vlrs_pkg::S_IDLE && $stable(sp_r);
    endsequence

    property p_hold_final;
        @(posedge core_clk_i) disable iff (srst_i)
        s_last_expire ##1 !(wr_go || $past(wr_go)) |-> s_hold_final;
    endproperty
    a_hold_final: assert property (p_hold_final) else $error("final entry not held");
    property p_start_only_armed;
        @(posedge core_clk_i) disable iff (srst_i)
        (st_r == vlrs_pkg::S_RUN && $past(st_r) != vlrs_pkg::S_RUN) |-> $past(st_r == vlrs_pkg::S_ARMED && trig);
    endproperty
    a_start_only_armed: assert property (p_start_only_armed) else $error("list started without armed trigger");
    property p_imm_trig;
        @(posedge core_clk_i) disable iff (srst_i)
        (st_r == vlrs_pkg::S_ARMED && cmd_trig && !cmd_abort) |=> st_r == vlrs_pkg::S_RUN && idx_r == '0;
    endproperty
    a_imm_trig: assert property (p_imm_trig) else $error("immediate trigger not accepted");
    property p_in_order;
        @(posedge core_clk_i) disable iff (srst_i)
        (st_r == vlrs_pkg::S_RUN && idx_r != $past(idx_r)) |-> idx_r == $past(idx_r) + ONE_I || idx_r == '0;
    endproperty
    a_in_order: assert property (p_in_order) else $error("list index skipped");
    property p_setpoint_sel;
        @(posedge core_clk_i) disable iff (srst_i)
        $past(!srst_i) |-> sp_r == ((ctrl_r[`VLRS_CTRL_LIST] && act_r) ? vlist_r[idx_r] : level_r);
    endproperty
    a_setpoint_sel: assert property (p_setpoint_sel) else $error("setpoint source wrong");
    property p_single_dwell;
        @(posedge core_clk_i) disable iff (srst_i)
        (sif.dwell_load && ndw_r == ONE_I && dlist_r[0] >= `VLRS_MIN_DWELL_MS) |-> sif.dwell_ms == dlist_r[0];
    endproperty
    a_single_dwell: assert property (p_single_dwell) else $error("shared dwell not used");
    property p_min_dwell;
        @(posedge core_clk_i) disable iff (srst_i)
        sif.dwell_load |-> sif.dwell_ms >= `VLRS_MIN_DWELL_MS;
    endproperty
    a_min_dwell: assert property (p_min_dwell) else $error("dwell below minimum");
    property p_done_irq;
        @(posedge core_clk_i) disable iff (srst_i)
        (evt_done && imsk_r[`VLRS_IST_DONE]) |=> ##1 irq_o;
    endproperty
    a_done_irq: assert property (p_done_irq) else $error("completion request missing");
    property p_wtg_bit;
        @(posedge core_clk_i) disable iff (srst_i)
        (req && !ack_r && wb_adr_i == `VLRS_OFS_OPER) |=> wb_ack_o && wb_dat_o[`VLRS_OPER_WTG] == $past(st_r == vlrs_pkg::S_ARMED);
    endproperty
    a_wtg_bit: assert property (p_wtg_bit) else $error("waiting bit misreported");
endmodule : vlrs_top
